// ==== rtl/tcsd_dma.sv ====
`timescale 1ns/10ps
// Overview of operation
// - Two independent channels steal single bus slots from the CPU.
// - Fixed/increment address modes in 1M space; own register range 0x20-0x3F never accessed.
// - Source and destination never both incrementing; one pointer increments at most.
// - Sixteen-bit counter gives up to 64K units per block.
// - Channel zero uses pin zero, channel one pin one; falling or both edges.
// - Timer, serial, A-D and software requests are selectable sources.
// - Simultaneous requests: channel zero transfers first.
// - Single mode: counter underflow clears enable, channel goes inactive.
// - Repeat mode: underflow reloads counter, channel stays active until enable cleared.
// - Transfer-complete request pulses when the counter underflows.
// - Enabled channel does one unit per request; disabled channel does none.
// - First transfer after activation loads working pointer and counter.
// - Incrementing register always writable; fixed register only while disabled.
// - All registers readable; enabled incrementing register reads working pointer.
// - Transfers neither consume interrupts nor depend on interrupt masking.
// - Each unit is source reads followed by destination writes.
// - Sixteen-bit unit at odd address needs two accesses on that side: two reads from odd source, two writes to odd destination.
// - Byte-wide bus splits a sixteen-bit unit into two byte accesses each side.
// - All areas, internal too, are accessed at the bus-width pin width.
// - SFR area or software-wait area access lengthened by one cycle.
// - Unit cycles follow read and write counts times area coefficients; size bit one means bytes.
// - Writing enable one on an active channel restarts it from initial state.
// - Request flag sets on every request, clears at start, software may only clear.
// - After channel zero, CPU gets one access before channel one runs.
module tcsd_dma
    import tcsd_pkg::*;
#(
    parameter int NUM_PERIPH = 20
) (
    // Clock and reset
    input  wire logic                    clk_i,
    input  wire logic                    rst_n_i,
    // Register bus
    input  wire logic [TCSD_AVS_AW-1:0]  avs_address_i,
    input  wire logic                    avs_read_i,
    input  wire logic                    avs_write_i,
    input  wire logic [31:0]             avs_writedata_i,
    input  wire logic [3:0]              avs_byteenable_i,
    output logic      [31:0]             avs_readdata_o,
    output logic                         avs_waitrequest_o,
    // Request sources
    input  wire logic                    ext_irq_pin_zero_i,
    input  wire logic                    ext_irq_pin_one_i,
    input  wire logic [NUM_PERIPH-1:0]   periph_req_i,
    // System bus master side
    output logic                         bus_steal_o,
    input  wire logic                    cpu_slot_i,
    output tcsd_mem_req_s                mem_req_o,
    input  wire logic                    mem_ack_i,
    input  wire logic [15:0]             mem_rdata_i,
    // Bus configuration
    input  wire logic                    byte_bus_i,
    input  wire logic                    sw_wait_i,
    // Completion requests
    output logic      [1:0]              done_o
);

    tcsd_state_s         q;
    tcsd_state_s         d;
    tcsd_chan_s          ch;
    logic [19:0]         sa;
    logic [19:0]         da;
    logic [19:0]         base;
    logic [19:0]         acc_addr;
    logic                two;
    logic                need_wait;
    logic                prot;
    logic                acc_done;
    logic [15:0]         rdat;
    logic [1:0]          pins;
    logic [1:0]          ev;
    logic [31:0]         wm;
    logic [4:0]          off;
    logic                wch;
    logic                mapped;
    logic                pick_ok;
    logic                pick;

    function automatic logic [31:0] tcsd_reg_val(input tcsd_chan_s c, input logic [4:0] o, input logic live);
        logic [31:0] v;
        v = '0;
        case (o)
            OFF_SRC:  v[19:0] = (live && c.en && c.sinc) ? c.fwd : c.src;
            OFF_DST:  v[19:0] = (live && c.en && c.dinc) ? c.fwd : c.dst;
            OFF_RLD:  v[15:0] = c.rld;
            OFF_CNT:  v[15:0] = c.cnt;
            OFF_CTRL: begin
                v[CTRL_SIZE] = c.size8;
                v[CTRL_RPT]  = c.rpt;
                v[CTRL_REQ]  = c.req;
                v[CTRL_EN]   = c.en;
                v[CTRL_SINC] = c.sinc;
                v[CTRL_DINC] = c.dinc;
            end
            OFF_SEL: begin
                v[4:0]      = c.sel;
                v[SEL_BOTH] = c.both;
            end
            default:  v = '0;
        endcase
        return v;
    endfunction : tcsd_reg_val

    function automatic logic [31:0] tcsd_merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                r[b*8 +: 8] = wd[b*8 +: 8];
            end
        end
        return r;
    endfunction : tcsd_merge

    assign pins              = {ext_irq_pin_one_i, ext_irq_pin_zero_i};
    assign off               = {avs_address_i[4:2], 2'b00};
    assign wch               = avs_address_i[5];
    assign mapped            = ~avs_address_i[6];
    assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~q.ack;
    assign avs_readdata_o    = q.rdata;
    assign mem_req_o         = q.mem;
    assign done_o            = q.done;
    assign bus_steal_o       = (q.st == ST_RD) || (q.st == ST_WR);

    always_comb begin
        d        = q;
        d.done   = '0;
        d.ack    = 1'b0;
        acc_done = 1'b0;
        rdat     = '0;
        pick_ok  = 1'b0;
        pick     = 1'b0;
        wm       = '0;
        ev       = '0;

        // Current unit addressing
        ch        = q.chan[q.cur];
        sa        = ch.sinc ? ch.fwd : ch.src;
        da        = ch.dinc ? ch.fwd : ch.dst;
        base      = (q.st == ST_WR) ? da : sa;
        two       = ~ch.size8 & (byte_bus_i | base[0]);
        acc_addr  = base + {19'h0_0000, q.half};
        need_wait = (acc_addr <= SFR_HI) | sw_wait_i;
        prot      = (acc_addr >= PROT_LO) && (acc_addr <= PROT_HI);

        case (q.st)
            ST_IDLE: begin
                if (q.chan[0].en && q.chan[0].req) begin
                    pick_ok = 1'b1;
                    pick    = 1'b0;
                end else if (q.chan[1].en && q.chan[1].req) begin
                    pick_ok = 1'b1;
                    pick    = 1'b1;
                end
                if (pick_ok) begin
                    d.cur  = pick;
                    d.st   = ST_RD;
                    d.half = 1'b0;
                    d.chan[pick].req = 1'b0;
                    if (q.chan[pick].first) begin
                        d.chan[pick].fwd   = q.chan[pick].sinc ? q.chan[pick].src : q.chan[pick].dst;
                        d.chan[pick].cnt   = q.chan[pick].rld;
                        d.chan[pick].first = 1'b0;
                    end
                end
            end
            ST_RD, ST_WR: begin
                if (!q.mem.valid) begin
                    if (need_wait && !q.waited) begin
                        d.waited = 1'b1;
                    end else if (prot) begin
                        acc_done = 1'b1;
                    end else begin
                        d.mem.valid = 1'b1;
                        d.mem.wr    = (q.st == ST_WR);
                        d.mem.byte8 = ch.size8 | two;
                        d.mem.addr  = acc_addr;
                        d.mem.wdata = two ? {8'h00, (q.half ? q.dat[15:8] : q.dat[7:0])} : q.dat;
                    end
                end else if (mem_ack_i) begin
                    acc_done    = 1'b1;
                    rdat        = mem_rdata_i;
                    d.mem.valid = 1'b0;
                end
                if (acc_done) begin
                    d.waited = 1'b0;
                    if (q.st == ST_RD) begin
                        if (two && q.half) begin
                            d.dat[15:8] = rdat[7:0];
                        end else if (two) begin
                            d.dat[7:0] = rdat[7:0];
                        end else begin
                            d.dat = ch.size8 ? {8'h00, rdat[7:0]} : rdat;
                        end
                    end
                    if (two && !q.half) begin
                        d.half = 1'b1;
                    end else begin
                        d.half = 1'b0;
                        if (q.st == ST_RD) begin
                            d.st = ST_WR;
                        end else begin
                            d.st = ST_YLD;
                            d.chan[q.cur].fwd = ch.fwd + (ch.size8 ? 20'h0_0001 : 20'h0_0002);
                            if (ch.cnt == 16'h0000) begin
                                d.done[q.cur] = 1'b1;
                                if (ch.rpt) begin
                                    d.chan[q.cur].cnt = ch.rld;
                                end else begin
                                    d.chan[q.cur].en = 1'b0;
                                end
                            end else begin
                                d.chan[q.cur].cnt = ch.cnt - 16'h0001;
                            end
                        end
                    end
                end
            end
            ST_YLD: begin
                if (cpu_slot_i) begin
                    d.st = ST_IDLE;
                end
            end
            default: d.st = ST_IDLE;
        endcase

        // Register bus: read data captured on the first cycle, write applied on the answer edge
        if ((avs_read_i || avs_write_i) && !q.ack) begin
            d.ack   = 1'b1;
            d.rdata = (mapped && avs_read_i) ? tcsd_reg_val(q.chan[wch], off, 1'b1) : 32'h0000_0000;
        end
        if (avs_write_i && q.ack && mapped) begin
            wm = tcsd_merge(tcsd_reg_val(q.chan[wch], off, 1'b0), avs_writedata_i, avs_byteenable_i);
            case (off)
                OFF_SRC: begin
                    if (q.chan[wch].sinc || !q.chan[wch].en) begin
                        d.chan[wch].src = wm[19:0];
                    end
                end
                OFF_DST: begin
                    if (q.chan[wch].dinc || !q.chan[wch].en) begin
                        d.chan[wch].dst = wm[19:0];
                    end
                end
                OFF_RLD:  d.chan[wch].rld = wm[15:0];
                OFF_CTRL: begin
                    d.chan[wch].size8 = wm[CTRL_SIZE];
                    d.chan[wch].rpt   = wm[CTRL_RPT];
                    d.chan[wch].sinc  = wm[CTRL_SINC];
                    d.chan[wch].dinc  = wm[CTRL_DINC] & ~wm[CTRL_SINC];
                    if (!wm[CTRL_REQ]) begin
                        d.chan[wch].req = 1'b0;
                    end
                    d.chan[wch].en = wm[CTRL_EN];
                    if (wm[CTRL_EN]) begin
                        d.chan[wch].first = 1'b1;
                    end
                end
                OFF_SEL: begin
                    d.chan[wch].sel  = wm[4:0];
                    d.chan[wch].both = wm[SEL_BOTH];
                end
                OFF_SWRQ: ev[wch] = avs_byteenable_i[0] & avs_writedata_i[SWRQ_GO];
                default: d.rdata = q.rdata;
            endcase
        end

        // Request sources; a set beats any clear in the same cycle
        d.pin_prev = pins;
        for (int c = 0; c < 2; c++) begin
            if (q.chan[c].sel == SRC_EXT_PIN) begin
                if (q.chan[c].both) begin
                    ev[c] = ev[c] | (q.pin_prev[c] ^ pins[c]);
                end else begin
                    ev[c] = ev[c] | (q.pin_prev[c] & ~pins[c]);
                end
            end
            for (int p = 0; p < NUM_PERIPH; p++) begin
                if ((q.chan[c].sel == 5'(p + 1)) && periph_req_i[p]) begin
                    ev[c] = 1'b1;
                end
            end
            if (ev[c]) begin
                d.chan[c].req = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            q             <= '0;
            q.st          <= ST_IDLE;
            q.pin_prev    <= RST_PIN_PREV;
            q.chan[0].sel <= RST_SEL;
            q.chan[1].sel <= RST_SEL;
        end else begin
            q <= d;
        end
    end

endmodule : tcsd_dma

// ==== rtl/tcsd_pkg.sv ====
package tcsd_pkg;

    // Address space and bus geometry
    localparam int          TCSD_AW       = 20;
    localparam int          TCSD_CW       = 16;
    localparam int          TCSD_AVS_AW   = 7;

    // Register offsets inside one channel block; channel one sits at bit 5 of the byte address
    localparam logic [4:0]  OFF_SRC       = 5'h00;
    localparam logic [4:0]  OFF_DST       = 5'h04;
    localparam logic [4:0]  OFF_RLD       = 5'h08;
    localparam logic [4:0]  OFF_CTRL      = 5'h0C;
    localparam logic [4:0]  OFF_SEL       = 5'h10;
    localparam logic [4:0]  OFF_CNT       = 5'h14;
    localparam logic [4:0]  OFF_SWRQ      = 5'h18;

    // Control register fields
    localparam int          CTRL_SIZE     = 0;
    localparam int          CTRL_RPT      = 1;
    localparam int          CTRL_REQ      = 2;
    localparam int          CTRL_EN       = 3;
    localparam int          CTRL_SINC     = 4;
    localparam int          CTRL_DINC     = 5;

    // Request source select fields and codes
    localparam int          SEL_BOTH      = 8;
    localparam int          SWRQ_GO       = 0;
    localparam logic [4:0]  SRC_EXT_PIN   = 5'h00;
    localparam logic [4:0]  SRC_SW_ONLY   = 5'h1F;

    // Reset values
    localparam logic [4:0]  RST_SEL       = SRC_SW_ONLY;
    localparam logic [1:0]  RST_PIN_PREV  = 2'h3;

    // Target address areas
    localparam logic [19:0] PROT_LO       = 20'h0_0020;
    localparam logic [19:0] PROT_HI       = 20'h0_003F;
    localparam logic [19:0] SFR_HI        = 20'h0_03FF;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_RD   = 4'b0010,
        ST_WR   = 4'b0100,
        ST_YLD  = 4'b1000
    } tcsd_st_e;

    typedef struct packed {
        logic [19:0] src;
        logic [19:0] dst;
        logic [19:0] fwd;
        logic [15:0] rld;
        logic [15:0] cnt;
        logic        size8;
        logic        rpt;
        logic        sinc;
        logic        dinc;
        logic        en;
        logic        req;
        logic        first;
        logic [4:0]  sel;
        logic        both;
    } tcsd_chan_s;

    typedef struct packed {
        logic        valid;
        logic        wr;
        logic        byte8;
        logic [19:0] addr;
        logic [15:0] wdata;
    } tcsd_mem_req_s;

    typedef struct packed {
        tcsd_st_e            st;
        tcsd_chan_s [1:0]    chan;
        logic                cur;
        logic                half;
        logic                waited;
        logic [15:0]         dat;
        tcsd_mem_req_s       mem;
        logic                ack;
        logic [31:0]         rdata;
        logic [1:0]          pin_prev;
        logic [1:0]          done;
    } tcsd_state_s;

endpackage : tcsd_pkg

// ==== dv/tcsd_dma_properties.sv ====
`timescale 1ns/10ps
module tcsd_dma_properties
    import tcsd_pkg::*;
(
    // Clock and reset
    input wire logic                   clk_i,
    input wire logic                   rst_n_i,
    // Register bus
    input wire logic [TCSD_AVS_AW-1:0] avs_address_i,
    input wire logic                   avs_read_i,
    input wire logic                   avs_write_i,
    input wire logic [31:0]            avs_readdata_o,
    input wire logic                   avs_waitrequest_o,
    // System bus
    input wire logic                   bus_steal_o,
    input wire logic                   cpu_slot_i,
    input wire tcsd_mem_req_s          mem_req_o,
    input wire logic                   mem_ack_i,
    input wire logic                   byte_bus_i,
    input wire logic                   sw_wait_i,
    input wire logic [1:0]             done_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    logic slot_q;
    wire logic acc = mem_req_o.valid && mem_ack_i;

    // Remembers that the CPU got a slot since the last stolen unit
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            slot_q <= 1'b1;
        end else if (bus_steal_o) begin
            slot_q <= 1'b0;
        end else if (cpu_slot_i) begin
            slot_q <= 1'b1;
        end
    end

    bus_answer_a: assert property (
        (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o) else $error("no register answer");
    unmapped_zero_a: assert property (
        avs_read_i && !avs_waitrequest_o && avs_address_i[6] |-> avs_readdata_o == 32'h0000_0000)
        else $error("unmapped read not zero");
    own_range_a: assert property (
        mem_req_o.valid |-> !(mem_req_o.addr >= PROT_LO && mem_req_o.addr <= PROT_HI))
        else $error("access to own register range");
    req_hold_a: assert property (mem_req_o.valid && !mem_ack_i |=> $stable(mem_req_o))
        else $error("memory request changed before ack");
    steal_cover_a: assert property (mem_req_o.valid |-> bus_steal_o)
        else $error("access without bus steal");
    cpu_yield_a: assert property ($rose(bus_steal_o) |-> slot_q)
        else $error("unit started without a cpu slot");
    done_cause_a: assert property ($rose(|done_o) |-> $past(acc && mem_req_o.wr))
        else $error("done without a write");
    byte_width_a: assert property (mem_req_o.valid && byte_bus_i |-> mem_req_o.byte8)
        else $error("word access on byte bus");
    wait_gap_a: assert property (acc && sw_wait_i |=> !mem_req_o.valid [*2])
        else $error("wait cycle missing");
endmodule : tcsd_dma_properties

bind tcsd_dma tcsd_dma_properties tcsd_dma_properties_i (.clk_i, .rst_n_i, .avs_address_i, .avs_read_i,
    .avs_write_i, .avs_readdata_o, .avs_waitrequest_o, .bus_steal_o, .cpu_slot_i, .mem_req_o, .mem_ack_i,
    .byte_bus_i, .sw_wait_i, .done_o);

// ==== dv/tcsd_mem_model.sv ====
`timescale 1ns/10ps
module tcsd_mem_model
    import tcsd_pkg::*;
(
    // Clock and answer delay
    input  wire logic          clk_i,
    input  wire logic [3:0]    dly_i,
    // Bus requests
    input  wire tcsd_mem_req_s req_i,
    input  wire logic          bus_steal_i,
    output logic               ack_o,
    output logic [15:0]        rdata_o,
    output logic               slot_o,
    // Access counts
    output int                 rd_n_o,
    output int                 wr_n_o
);
    logic [7:0] mem [int];
    logic [3:0] wait_q = 4'h0;
    initial ack_o = 1'b0;
    initial rdata_o = 16'h0000;
    initial slot_o = 1'b0;
    initial rd_n_o = 0;
    initial wr_n_o = 0;

    // Little-endian byte memory; released data lines toggle every cycle
    always @(posedge clk_i) begin
        ack_o <= 1'b0;
        rdata_o <= ~rdata_o;
        slot_o <= !bus_steal_i;
        if (req_i.valid && !ack_o) begin
            if (wait_q < dly_i) begin
                wait_q <= wait_q + 4'h1;
            end else begin
                wait_q <= 4'h0;
                ack_o <= 1'b1;
                if (req_i.wr) begin
                    wr_n_o <= wr_n_o + 1;
                    mem[req_i.addr] = req_i.wdata[7:0];
                    if (!req_i.byte8) mem[req_i.addr + 20'h1] = req_i.wdata[15:8];
                end else begin
                    rd_n_o <= rd_n_o + 1;
                    rdata_o <= {req_i.byte8 ? ~rdata_o[15:8] : mem[req_i.addr + 20'h1], mem[req_i.addr]};
                end
            end
        end
    end
endmodule : tcsd_mem_model

// ==== dv/tcsd_dma_tb.sv ====
`timescale 1ns/10ps
module tcsd_dma_tb
    import tcsd_pkg::*;
();
    logic          clk;
    logic          rst_n = 1'b0, rd_en = 1'b0, wr_en = 1'b0, pin0 = 1'b1, pin1 = 1'b1;
    logic          byte_bus = 1'b0, sw_wait = 1'b0, steal, slot, ack, wreq;
    logic [6:0]    adr = 7'h00;
    logic [31:0]   wdat = 32'h0000_0000, rdat, q;
    logic [19:0]   preq = 20'h0_0000;
    logic [15:0]   mdat;
    logic [3:0]    dly = 4'h0;
    logic [1:0]    done;
    tcsd_mem_req_s mreq;
    int            failures = 0, tests_run = 0, rn, wn, n0, dn[2] = '{0, 0};
    logic [19:0]   wq[$];

    tcsd_dma tcsd_dma_i (.clk_i(clk), .rst_n_i(rst_n), .avs_address_i(adr), .avs_read_i(rd_en),
        .avs_write_i(wr_en), .avs_writedata_i(wdat), .avs_byteenable_i(4'hF), .avs_readdata_o(rdat),
        .avs_waitrequest_o(wreq), .ext_irq_pin_zero_i(pin0), .ext_irq_pin_one_i(pin1), .periph_req_i(preq),
        .bus_steal_o(steal), .cpu_slot_i(slot), .mem_req_o(mreq), .mem_ack_i(ack), .mem_rdata_i(mdat),
        .byte_bus_i(byte_bus), .sw_wait_i(sw_wait), .done_o(done));
    tcsd_mem_model mdl_i (.clk_i(clk), .dly_i(dly), .req_i(mreq), .bus_steal_i(steal), .ack_o(ack),
        .rdata_o(mdat), .slot_o(slot), .rd_n_o(rn), .wr_n_o(wn));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    always @(posedge clk) begin
        dn[0] <= dn[0] + int'(done[0]);
        dn[1] <= dn[1] + int'(done[1]);
        if (mreq.valid && ack && mreq.wr) wq.push_back(mreq.addr);
    end

    task automatic close_out;
        $display("failures=%0d tests_run=%0d", failures, tests_run);
        if (failures == 0 && tests_run > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : close_out

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e) begin
            failures++;
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk

    function automatic logic [6:0] ra(input logic c, input logic [4:0] o);
        return {1'b0, c, o};
    endfunction : ra

    task automatic bus(input logic [6:0] a, input logic w, input logic [31:0] d);
        int i;
        @(posedge clk);
        adr <= a;
        wdat <= d;
        wr_en <= w;
        rd_en <= !w;
        for (i = 0; i < 20; i++) begin
            @(posedge clk);
            if (wreq === 1'b0) break;
        end
        chk({31'h0, i == 20}, 32'h0);
        if (i == 20) close_out;
        q = rdat;
        wr_en <= 1'b0;
        rd_en <= 1'b0;
    endtask : bus

    task automatic rdc(input logic [6:0] a, input logic [31:0] e);
        bus(a, 1'b0, 32'h0);
        chk(q, e);
    endtask : rdc

    task automatic wait_wr(input int n);
        int i;
        for (i = 0; i < 400 && wn < n; i++) @(posedge clk);
        chk({31'h0, wn < n}, 32'h0);
        if (wn < n) close_out;
        repeat (3) @(posedge clk);
    endtask : wait_wr

    task automatic sw(input logic c, input int n);
        bus(ra(c, OFF_SWRQ), 1'b1, 32'h0000_0001);
        wait_wr(n);
    endtask : sw

    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 6; i++) mdl_i.mem[32'h1000 + i] = 8'h11 + 8'(i);
        rdc(ra(0, OFF_SEL), {27'h0, RST_SEL});
        rdc(ra(0, OFF_CTRL), 32'h0000_0000);
        bus(7'h40, 1'b1, 32'hFFFF_FFFF);
        rdc(7'h40, 32'h0000_0000);
        // Channel zero: single mode, incrementing source, three units
        bus(ra(0, OFF_SRC), 1'b1, 32'h0000_1000);
        bus(ra(0, OFF_DST), 1'b1, 32'h0000_2000);
        bus(ra(0, OFF_RLD), 1'b1, 32'h0000_0002);
        bus(ra(0, OFF_CTRL), 1'b1, 32'h0000_0018);
        bus(ra(0, OFF_DST), 1'b1, 32'h0000_3000);
        rdc(ra(0, OFF_DST), 32'h0000_2000);
        sw(0, 1);
        rdc(ra(0, OFF_SRC), 32'h0000_1002);
        rdc(ra(0, OFF_CNT), 32'h0000_0001);
        sw(0, 2);
        sw(0, 3);
        chk({16'h0, mdl_i.mem[32'h2001], mdl_i.mem[32'h2000]}, 32'h0000_1615);
        chk(32'(dn[0]), 32'h1);
        rdc(ra(0, OFF_CTRL), 32'h0000_0010);
        bus(ra(0, OFF_SWRQ), 1'b1, 32'h0000_0001);
        repeat (6) @(posedge clk);
        chk(32'(wn), 32'h3);
        rdc(ra(0, OFF_CTRL), 32'h0000_0014);
        bus(ra(0, OFF_CTRL), 1'b1, 32'h0000_0010);
        bus(ra(0, OFF_CTRL), 1'b1, 32'h0000_0014);
        rdc(ra(0, OFF_CTRL), 32'h0000_0010);
        bus(ra(0, OFF_CTRL), 1'b1, 32'h0000_0030);
        rdc(ra(0, OFF_CTRL), 32'h0000_0010);
        // Channel one: repeat mode, words on a byte bus, waits, slow memory
        byte_bus <= 1'b1;
        sw_wait <= 1'b1;
        dly <= 4'h3;
        bus(ra(1, OFF_SRC), 1'b1, 32'h0000_1000);
        bus(ra(1, OFF_DST), 1'b1, 32'h0000_3001);
        bus(ra(1, OFF_RLD), 1'b1, 32'h0000_0000);
        bus(ra(1, OFF_CTRL), 1'b1, 32'h0000_002A);
        n0 = rn;
        sw(1, 5);
        chk(32'(rn - n0), 32'h2);
        chk({16'h0, mdl_i.mem[32'h3002], mdl_i.mem[32'h3001]}, 32'h0000_1211);
        chk(32'(dn[1]), 32'h1);
        rdc(ra(1, OFF_CTRL), 32'h0000_002A);
        rdc(ra(1, OFF_CNT), 32'h0000_0000);
        byte_bus <= 1'b0;
        n0 = rn;
        sw(1, 7);
        chk(32'(rn - n0), 32'h1);
        chk({16'h0, mdl_i.mem[32'h3004], mdl_i.mem[32'h3003]}, 32'h0000_1211);
        rdc(ra(1, OFF_DST), 32'h0000_3005);
        // Both pins fall together, channel one also on rising edges
        sw_wait <= 1'b0;
        dly <= 4'h0;
        bus(ra(1, OFF_CTRL), 1'b1, 32'h0000_0000);
        bus(ra(1, OFF_DST), 1'b1, 32'h0000_3000);
        bus(ra(1, OFF_RLD), 1'b1, 32'h0000_0001);
        bus(ra(1, OFF_SEL), 1'b1, 32'h0000_0100);
        bus(ra(1, OFF_CTRL), 1'b1, 32'h0000_0008);
        bus(ra(0, OFF_RLD), 1'b1, 32'h0000_0001);
        bus(ra(0, OFF_SEL), 1'b1, 32'h0000_0000);
        bus(ra(0, OFF_CTRL), 1'b1, 32'h0000_0008);
        wq.delete();
        pin0 <= 1'b0;
        pin1 <= 1'b0;
        wait_wr(9);
        chk({12'h0, wq[0]}, 32'h0000_2000);
        chk({12'h0, wq[1]}, 32'h0000_3000);
        pin0 <= 1'b1;
        pin1 <= 1'b1;
        wait_wr(10);
        repeat (8) @(posedge clk);
        chk(32'(wn), 32'hA);
        chk(32'(dn[1]), 32'h3);
        // Peripheral request source on channel zero
        bus(ra(0, OFF_SEL), 1'b1, 32'h0000_0005);
        preq <= 20'h0_0010;
        @(posedge clk);
        preq <= 20'h0_0000;
        wait_wr(11);
        chk({12'h0, wq[3]}, 32'h0000_2000);
        chk(32'(dn[0]), 32'h2);
        // Byte units from an odd source on channel zero
        bus(ra(0, OFF_SRC), 1'b1, 32'h0000_1005);
        bus(ra(0, OFF_CTRL), 1'b1, 32'h0000_0019);
        n0 = rn;
        sw(0, 12);
        chk(32'(rn - n0), 32'h1);
        chk({16'h0, mdl_i.mem[32'h2001], mdl_i.mem[32'h2000]}, 32'h0000_1216);
        rdc(ra(0, OFF_SRC), 32'h0000_1006);
        close_out;
    end
endmodule : tcsd_dma_tb
